// ---- logic/nvp_pkg.sv ----
// Constants and types of the parallel programming controller.
// Functional notes
// [RULE_01] Erase-all clears flash, EEPROM and lock bits.
// [RULE_02] Lock bits released only after flash erase.
// [RULE_03] Preserve fuse keeps EEPROM through erase-all.
// [RULE_04] Programmer erases all before any reprogramming.
// [RULE_05] Programmer may skip 0xFF writes after erase.
// [RULE_06] Command and address are retained between loads.
// [RULE_07] Command load: select 10, byte-select low, strobe.
// [RULE_08] Erase starts on write pulse; wait ready.
// [RULE_09] Decode flash write, EEPROM write, flash read.
// [RULE_10] Select 00 loads address byte, byte-select picks.
// [RULE_11] Select 01 loads data byte, byte-select picks.
// [RULE_12] Page latch, byte-select high, fills buffer word.
// [RULE_13] Repeat address, data, latch; then program page.
// [RULE_14] Low address bits word, high bits page.
// [RULE_15] Write pulse, byte-select low, programs page; wait.
// [RULE_16] No-operation command ends page programming.
// [RULE_17] EEPROM page: command, high, low, data, latch.
// [RULE_18] Read drives low/high byte while enable low.
// [RULE_19] Ready high when idle; busy ignores writes.
// [RULE_20] Device drives bus only during read enable.
`default_nettype none

package nvp_pkg;

    // Pin step time; each strobe phase lasts one step.
    localparam int CLK_MHZ = 100;
    localparam int STEP_NS = 100;
    localparam int STEP_CYC = (STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int TICK_W = 8;
    // Steps to wait for busy after a write pulse.
    localparam int SETTLE_STEPS = 4;
    localparam int SETTLE_W = 4;

    // Command bytes.
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;

    // Action select pair codes {hi, lo}.
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [1:0] ACT_IDLE = 2'h3;

    // Register map, byte offsets on the bus.
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;

    // Control register fields.
    localparam int CTRL_DATA_LSB = 0;
    localparam int CTRL_BSEL_BIT = 8;
    localparam int CTRL_OP_LSB = 12;

    // Status register fields.
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_READY_BIT = 1;
    localparam int ST_ERASED_BIT = 2;
    localparam int ST_REFUSED_BIT = 3;
    localparam int ST_RDATA_LSB = 8;
    localparam int ST_CMD_LSB = 16;

    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [2:0] {
        OP_CMD = 3'h0,
        OP_ADDR = 3'h1,
        OP_DATA = 3'h2,
        OP_LATCH = 3'h3,
        OP_WRITE = 3'h4,
        OP_READ = 3'h5,
        OP_BAD6 = 3'h6,
        OP_BAD7 = 3'h7
    } nvp_op_e;

endpackage

`default_nettype wire

// ---- logic/nvp_req_if.sv ----
// Request and status bundle between the register slave and the pin sequencer.
`timescale 1ns/1ps
`default_nettype none

interface nvp_req_if;
    import nvp_pkg::*;
    logic req, bsel, busy, refused_evt, ready, erased;
    nvp_op_e op;
    logic [7:0] data, rd_data, cmd;

    modport regs (
        output req, op, bsel, data,
        input busy, refused_evt, ready, erased, rd_data, cmd
    );
    modport seq (
        input req, op, bsel, data,
        output busy, refused_evt, ready, erased, rd_data, cmd
    );
endinterface

`default_nettype wire

// ---- logic/nvp_regs.sv ----
// Classic Wishbone register slave that issues pin operations and shows status.
`timescale 1ns/1ps
`default_nettype none

module nvp_regs
    import nvp_pkg::*;
(
    // Clock and synchronised reset
    input wire logic mclk,
    input wire logic rst_sync_n,
    // Wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [3:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack,
    // Sequencer side
    nvp_req_if.regs rq
);

    logic access, wr_ctrl, wr_status, op_legal, refused;
    nvp_op_e req_op;

    assign access = wb_cyc && wb_stb && !wb_ack;
    assign wr_ctrl = access && wb_we && (wb_adr == OFS_CTRL) && wb_sel[1];
    assign wr_status = access && wb_we && (wb_adr == OFS_STATUS) && wb_sel[0];
    assign req_op = nvp_op_e'(wb_dat_i[CTRL_OP_LSB +: 3]);
    assign op_legal = (req_op != OP_BAD6) && (req_op != OP_BAD7);

    // Ack follows the strobe by one cycle and lasts one cycle.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wb_ack <= 1'h0;
        end else begin
            wb_ack <= access;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wb_dat_o <= RST_WORD;
        end else if (access && !wb_we) begin
            wb_dat_o <= RST_WORD;
            if (wb_adr == OFS_STATUS) begin
                wb_dat_o[ST_BUSY_BIT] <= rq.busy;
                wb_dat_o[ST_READY_BIT] <= rq.ready;
                wb_dat_o[ST_ERASED_BIT] <= rq.erased;
                wb_dat_o[ST_REFUSED_BIT] <= refused;
                wb_dat_o[ST_RDATA_LSB +: 8] <= rq.rd_data;
                wb_dat_o[ST_CMD_LSB +: 8] <= rq.cmd;
            end
        end
    end

    // A new operation is only handed over while the sequencer is idle.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rq.req <= 1'h0;
            rq.op <= OP_CMD;
            rq.bsel <= 1'h0;
            rq.data <= RST_BYTE;
        end else begin
            rq.req <= wr_ctrl && op_legal && !rq.busy; // RULE_19
            if (wr_ctrl && !rq.busy) begin
                rq.op <= req_op;
                rq.bsel <= wb_dat_i[CTRL_BSEL_BIT];
                if (wb_sel[0]) begin
                    rq.data <= wb_dat_i[CTRL_DATA_LSB +: 8];
                end
            end
        end
    end

    // Sticky refusal flag; a new refusal wins over a clear in the same cycle.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            refused <= 1'h0;
        end else if ((wr_ctrl && (rq.busy || !op_legal)) || rq.refused_evt) begin
            refused <= 1'h1;
        end else if (wr_status && wb_dat_i[ST_REFUSED_BIT]) begin
            refused <= 1'h0;
        end
    end

endmodule

`default_nettype wire

// ---- logic/nvp_host.sv ----
// Parallel programming controller: bus registers plus the pin sequencer.
`timescale 1ns/1ps
`default_nettype none

module nvp_host
    import nvp_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [3:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack,
    // Device control pins
    output logic action_select_hi,
    output logic action_select_lo,
    output logic byte_select,
    output logic load_strobe,
    output logic page_latch_strobe,
    output logic write_n,
    output logic out_enable_n,
    input wire logic ready_busy_n,
    // Device data bus, split into its three signals
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_STROBE = 3'h2,
        ST_HOLD = 3'h3,
        ST_RELEASE = 3'h4,
        ST_WAIT_LOW = 3'h5,
        ST_WAIT_HIGH = 3'h6
    } nvp_state_e;

    logic [1:0] rst_pipe;
    logic rst_sync_n;
    logic rdy_meta;
    logic rdy_sync;
    logic [7:0] din_meta;
    logic [7:0] din_sync;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [SETTLE_W-1:0] settle_cnt;
    nvp_state_e state;
    nvp_op_e cur_op;
    logic [7:0] cmd_loaded;
    logic erased;
    logic [7:0] rd_byte;
    logic prog_cmd;
    logic refuse_now;

    nvp_req_if rq ();

    nvp_regs u_regs (
        .mclk,
        .rst_sync_n,
        .wb_cyc,
        .wb_stb,
        .wb_we,
        .wb_adr,
        .wb_sel,
        .wb_dat_i,
        .wb_dat_o,
        .wb_ack,
        .rq(rq.regs)
    );

    // Reset is asserted at once and released through two flip-flops.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'h1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // Pins from the device are asynchronous to mclk.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdy_meta <= 1'h0;
            rdy_sync <= 1'h0;
            din_meta <= RST_BYTE;
            din_sync <= RST_BYTE;
        end else begin
            rdy_meta <= ready_busy_n;
            rdy_sync <= rdy_meta;
            din_meta <= data_in;
            din_sync <= din_meta;
        end
    end

    // Step divider, restarted per request
    // so the first setup step is full.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tick_cnt <= '0;
        end else if (rq.req || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + TICK_W'(1);
        end
    end
    assign tick = (tick_cnt == TICK_W'(STEP_CYC - 1));

    // Only page-write commands need a preceding erase-all.
    assign prog_cmd = (cmd_loaded == CMD_WR_FLASH) || (cmd_loaded == CMD_WR_EEPROM);
    assign refuse_now = rq.req && (rq.op == OP_WRITE) && prog_cmd && !erased; // RULE_04

    // Sequencer: each operation starts with setup, strobe and hold, one step each.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= ST_IDLE;
            cur_op <= OP_CMD;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (rq.req && !refuse_now) begin
                        state <= ST_SETUP;
                        cur_op <= rq.op;
                    end
                end

                ST_SETUP: begin
                    if (tick) begin
                        state <= ST_STROBE;
                    end
                end

                ST_STROBE: begin
                    if (tick) begin
                        state <= ST_HOLD;
                    end
                end

                ST_HOLD: begin
                    if (tick) begin
                        if (cur_op == OP_READ) begin
                            state <= ST_RELEASE;
                        end else if (cur_op == OP_WRITE) begin
                            state <= ST_WAIT_LOW;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end

                ST_RELEASE: begin
                    if (tick) begin
                        state <= ST_IDLE;
                    end
                end

                ST_WAIT_LOW: begin
                    // A fast device may already be done, so the wait for busy is bounded.
                    if (!rdy_sync || (tick && settle_cnt == SETTLE_W'(SETTLE_STEPS - 1))) begin
                        state <= ST_WAIT_HIGH;
                    end
                end

                ST_WAIT_HIGH: begin
                    if (rdy_sync) begin
                        state <= ST_IDLE; // RULE_08 RULE_15
                    end
                end

                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            settle_cnt <= '0;
        end else if (state != ST_WAIT_LOW) begin
            settle_cnt <= '0;
        end else if (tick) begin
            settle_cnt <= settle_cnt + SETTLE_W'(1);
        end
    end

    // Select pins and data byte are set on acceptance and
    // held until the next op; a read turns the driver on again after its release step.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            action_select_hi <= ACT_IDLE[1];
            action_select_lo <= ACT_IDLE[0];
            byte_select <= 1'h0;
            data_out <= RST_BYTE;
            data_oe <= 1'h1;
        end else if (state == ST_IDLE && rq.req && !refuse_now) begin
            data_out <= rq.data;
            data_oe <= (rq.op != OP_READ); // RULE_20
            {action_select_hi, action_select_lo} <= ACT_IDLE;
            case (rq.op)
                OP_CMD: begin
                    {action_select_hi, action_select_lo} <= ACT_CMD; // RULE_07
                    byte_select <= 1'h0;
                end

                OP_ADDR: begin
                    {action_select_hi, action_select_lo} <= ACT_ADDR; // RULE_10
                    byte_select <= rq.bsel;
                end

                OP_DATA: begin
                    {action_select_hi, action_select_lo} <= ACT_DATA; // RULE_11
                    byte_select <= rq.bsel;
                end

                OP_LATCH: begin
                    byte_select <= 1'h1; // RULE_12
                end

                OP_WRITE: begin
                    byte_select <= 1'h0; // RULE_15 RULE_17
                end

                OP_READ: begin
                    byte_select <= rq.bsel; // RULE_18
                end
                default: begin
                    byte_select <= 1'h0;
                end
            endcase
        end else if (state == ST_RELEASE && tick) begin
            // Drive again only one step after the device has seen enable high.
            data_oe <= 1'h1; // RULE_20
        end
    end

    // Strobes: active for exactly the strobe step.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            load_strobe <= 1'h0;
            page_latch_strobe <= 1'h0;
            write_n <= 1'h1;
        end else if (state == ST_SETUP && tick) begin
            load_strobe <= (cur_op == OP_CMD) || (cur_op == OP_ADDR) || (cur_op == OP_DATA);
            page_latch_strobe <= (cur_op == OP_LATCH); // RULE_12 RULE_13
            write_n <= !(cur_op == OP_WRITE); // RULE_08 RULE_15
        end else if (state == ST_STROBE && tick) begin
            load_strobe <= 1'h0;
            page_latch_strobe <= 1'h0;
            write_n <= 1'h1;
        end
    end

    // Output enable spans strobe and hold; the byte is sampled at the end.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            out_enable_n <= 1'h1;
            rd_byte <= RST_BYTE;
        end else if (state == ST_SETUP && tick && cur_op == OP_READ) begin
            out_enable_n <= 1'h0; // RULE_18
        end else if (state == ST_HOLD && tick && cur_op == OP_READ) begin
            rd_byte <= din_sync;
            out_enable_n <= 1'h1;
        end
    end

    // Copy of the command the device retains;
    // software reloads only on change.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cmd_loaded <= CMD_NOP;
        end else if (state == ST_STROBE && tick && cur_op == OP_CMD) begin
            cmd_loaded <= data_out; // RULE_06 RULE_09 RULE_16
        end
    end

    // Set once an erase-all has finished.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            erased <= 1'h0;
        end else if (state == ST_WAIT_HIGH && rdy_sync && cmd_loaded == CMD_ERASE) begin
            erased <= 1'h1; // RULE_04 RULE_05
        end
    end

    assign rq.busy = (state != ST_IDLE);
    assign rq.refused_evt = refuse_now;
    assign rq.ready = rdy_sync;
    assign rq.erased = erased;
    assign rq.rd_data = rd_byte;
    assign rq.cmd = cmd_loaded;

endmodule

`default_nettype wire

// ---- tb/nvp_host_properties.sv ----
// Checker for the pin timing of the programming controller.
`timescale 1ns/1ps
`default_nettype none

module nvp_host_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Device pins
    input wire logic action_select_hi,
    input wire logic action_select_lo,
    input wire logic byte_select,
    input wire logic load_strobe,
    input wire logic page_latch_strobe,
    input wire logic write_n,
    input wire logic out_enable_n,
    input wire logic ready_busy_n,
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    AST_CMD_BSEL: assert property (
        $rose(load_strobe) && action_select_hi && !action_select_lo |-> !byte_select)
        else $error("command with byte select high");
    AST_LOAD_WIDTH: assert property (
        $rose(load_strobe) |-> load_strobe[*8] ##1 load_strobe ##1 load_strobe ##1 !load_strobe)
        else $error("load strobe width wrong");
    AST_LOAD_HOLD: assert property (
        load_strobe && $past(load_strobe) |->
        $stable({action_select_hi, action_select_lo, byte_select, data_out}) && data_oe)
        else $error("load inputs moved under strobe");
    AST_LATCH_BSEL: assert property (
        page_latch_strobe |-> byte_select && write_n && out_enable_n)
        else $error("latch with byte select low");
    AST_WRITE_BSEL: assert property (
        !write_n |-> !byte_select && out_enable_n && !load_strobe)
        else $error("write with byte select high");
    AST_WRITE_WIDTH: assert property (
        $fell(write_n) |-> !write_n[*8] ##1 !write_n ##1 !write_n ##1 write_n)
        else $error("write pulse width wrong");
    AST_LOAD_READY: assert property (
        $rose(load_strobe) |-> ready_busy_n && $past(ready_busy_n, 2))
        else $error("load while device busy");
    AST_BUS_FREE: assert property (
        !out_enable_n |-> !data_oe && $stable(byte_select))
        else $error("bus driven during read");
    AST_READ_WIDTH: assert property (
        $fell(out_enable_n) |-> !out_enable_n[*8] ##12 !out_enable_n ##1 out_enable_n)
        else $error("read enable width wrong");
endmodule

bind nvp_host nvp_host_props i_props (.mclk, .rst_n, .action_select_hi,
    .action_select_lo, .byte_select, .load_strobe, .page_latch_strobe, .write_n,
    .out_enable_n, .ready_busy_n, .data_out, .data_oe);

`default_nettype wire

// ---- tb/nvp_dev_model.sv ----
// Behavioural model of the memory device behind the programming pins.
`timescale 1ns/1ps
`default_nettype none

module nvp_dev_model
    import nvp_pkg::*;
#(
    parameter int PROG_NS = 2000,
    parameter int ERASE_NS = 5000
) (
    // Pins from the programmer, and the EEPROM preserve fuse
    input wire logic action_select_hi,
    input wire logic action_select_lo,
    input wire logic byte_select,
    input wire logic load_strobe,
    input wire logic page_latch_strobe,
    input wire logic write_n,
    input wire logic out_enable_n,
    input wire logic eeprom_preserve_fuse,
    // Data bus and status
    input wire logic [7:0] bus,
    output logic [7:0] dq,
    output logic ready_busy_n
);
    logic [7:0] cmd = 8'h00, ah = 8'h00, al = 8'h00, dlo = 8'h00, dhi = 8'h00, last = 8'h00;
    logic [15:0] rw;
    logic [15:0] flash [int];
    logic [7:0] eep [int];
    logic [15:0] pbuf [int];
    logic f_blank = 1'b0, e_blank = 1'b0;
    logic lock = 1'b1;
    logic wr_armed = 1'b0;
    int n_wr = 0;

    // Cells never erased read as zero, so a skipped erase cannot hide.
    function automatic logic [15:0] rd_f(input int a);
        return flash.exists(a) ? flash[a] : {16{f_blank}};
    endfunction
    function automatic logic [7:0] rd_e(input int a);
        return eep.exists(a) ? eep[a] : {8{e_blank}};
    endfunction

    initial begin
        ready_busy_n = 1'b1;
        dq = 8'hc3;
    end

    always @(posedge load_strobe) begin
        case ({action_select_hi, action_select_lo})
            ACT_CMD: begin
                cmd = bus;
                wr_armed = (bus == CMD_WR_FLASH) || (bus == CMD_WR_EEPROM);
                if (bus == CMD_NOP) begin
                    pbuf.delete();
                end
            end
            ACT_ADDR: begin
                if (byte_select) ah = bus;
                else al = bus;
            end
            ACT_DATA: begin
                if (byte_select) dhi = bus;
                else dlo = bus;
            end
            default: ;
        endcase
    end

    always @(posedge page_latch_strobe) begin
        if (byte_select) begin
            pbuf[cmd == CMD_WR_EEPROM ? int'(al[2:0]) : int'(al[6:0])] = {dhi, dlo};
        end
    end

    always @(negedge write_n) begin
        if (ready_busy_n && !byte_select && (wr_armed || cmd == CMD_ERASE)) begin
            n_wr++;
            ready_busy_n = 1'b0;
            if (cmd == CMD_ERASE) begin
                #(ERASE_NS / 2);
                flash.delete();
                f_blank = 1'b1;
                if (!eeprom_preserve_fuse) begin
                    eep.delete();
                    e_blank = 1'b1;
                end
                #(ERASE_NS / 2);
                lock = 1'b0;
            end else begin
                foreach (pbuf[w]) begin
                    if (cmd == CMD_WR_FLASH) flash[int'({ah, al[7], 7'(w)})] = pbuf[w];
                    else eep[int'({ah[2:0], al[7:3], 3'(w)})] = pbuf[w][7:0];
                end
                pbuf.delete();
                #(PROG_NS);
            end
            ready_busy_n = 1'b1;
        end
    end

    // A released bus shows the inverse of the last byte.
    always @(out_enable_n or byte_select or cmd or ah or al) begin
        if (!out_enable_n && cmd == CMD_RD_FLASH) begin
            rw = rd_f(int'({ah, al}));
            dq = byte_select ? rw[15:8] : rw[7:0];
            last = dq;
        end else begin
            dq = ~last;
        end
    end
endmodule

`default_nettype wire

// ---- tb/parallel_nvm_programming_port_tb_top.sv ----
// Self-checking bench for the parallel programming controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end

module parallel_nvm_programming_port_tb_top;
    import nvp_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, fuse = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [3:0] wb_sel = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, q;
    logic [7:0] data_out, dq;
    logic wb_ack, action_select_hi, action_select_lo, byte_select, load_strobe;
    logic page_latch_strobe, write_n, out_enable_n, ready_busy_n, data_oe;
    wire [7:0] bus = data_oe ? data_out : dq;
    int error_cnt = 0, n_tests = 0;
    logic [15:0] exp_f [int];
    logic [7:0] exp_e [int];
    int adrs [$];
    logic f_blank = 1'b0, erased = 1'b0;

    nvp_host i_dut (.mclk, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_i,
        .wb_dat_o, .wb_ack, .action_select_hi, .action_select_lo, .byte_select,
        .load_strobe, .page_latch_strobe, .write_n, .out_enable_n, .ready_busy_n,
        .data_in(bus), .data_out, .data_oe);
    nvp_dev_model i_dev (.action_select_hi, .action_select_lo, .byte_select, .load_strobe,
        .page_latch_strobe, .write_n, .out_enable_n, .eeprom_preserve_fuse(fuse), .bus,
        .dq, .ready_busy_n);

    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
        int k;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_i <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge mclk);
            if (wb_ack === 1'b1) break;
        end
        if (k == 20) begin
            error_cnt++;
            conclude();
        end
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic ctl(input nvp_op_e o, input logic bs, input logic [7:0] d);
        wb(1'b1, OFS_CTRL, {17'h0, o, 3'h0, bs, d});
    endtask

    // Polls until idle; q holds the last status.
    task automatic op(input nvp_op_e o, input logic bs, input logic [7:0] d);
        int k;
        ctl(o, bs, d);
        for (k = 0; k < 400; k++) begin
            wb(1'b0, OFS_STATUS, 32'h0);
            if (q[ST_BUSY_BIT] === 1'b0) break;
        end
        if (k == 400) begin
            error_cnt++;
            conclude();
        end
    endtask

    task automatic chk_st(input logic [7:0] c, input logic rf);
        wb(1'b0, OFS_STATUS, 32'h0);
        `CHK(q, {8'h00, c, 8'h00, 4'h0, rf, erased, 2'b10})
    endtask

    function automatic logic [15:0] ew(input int a);
        return exp_f.exists(a) ? exp_f[a] : {16{f_blank}};
    endfunction

    initial begin
        int a;
        logic [7:0] ah, al;
        logic [15:0] d;
        void'($urandom(32'hc1783d3f));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        wb(1'b0, 4'h8, 32'h0);
        `CHK(q, RST_WORD)
        chk_st(CMD_NOP, 1'b0);
        op(OP_CMD, 1'b0, CMD_WR_FLASH);
        op(OP_WRITE, 1'b0, 8'h00);
        chk_st(CMD_WR_FLASH, 1'b1);
        `CHK(i_dev.n_wr, 0)
        wb(1'b1, OFS_STATUS, 32'h0000_0008);
        $display("test reset and refusal done");
        op(OP_CMD, 1'b0, CMD_ERASE);
        ctl(OP_WRITE, 1'b0, 8'h00);
        ctl(OP_CMD, 1'b0, CMD_NOP);
        op(OP_CMD, 1'b0, CMD_ERASE);
        f_blank = 1'b1;
        erased = 1'b1;
        chk_st(CMD_ERASE, 1'b1);
        `CHK({i_dev.n_wr, i_dev.f_blank, i_dev.e_blank, i_dev.lock}, {32'h0000_0001, 3'b110})
        wb(1'b1, OFS_STATUS, 32'h0000_0008);
        $display("test erase done");
        op(OP_CMD, 1'b0, CMD_WR_FLASH);
        repeat (2) begin
            ah = 8'($urandom);
            al = {1'($urandom), 7'($urandom_range(0, 124))};
            for (int k = 0; k < 4; k++) begin
                d = 16'($urandom);
                if (d != 16'hffff) begin
                    op(OP_ADDR, 1'b0, al);
                    op(OP_DATA, 1'b0, d[7:0]);
                    op(OP_DATA, 1'b1, d[15:8]);
                    op(OP_LATCH, 1'b1, 8'h00);
                    exp_f[int'({ah, al})] = d;
                end
                adrs.push_back(int'({ah, al}));
                al++;
            end
            op(OP_ADDR, 1'b1, ah);
            op(OP_WRITE, 1'b0, 8'h00);
            adrs.push_back(int'({ah, al ^ 8'h40}));
        end
        op(OP_CMD, 1'b0, CMD_NOP);
        `CHK(i_dev.wr_armed, 1'b0)
        op(OP_CMD, 1'b0, CMD_RD_FLASH);
        foreach (adrs[i]) begin
            a = adrs[i];
            d = ew(a);
            if (i == 0 || a[15:8] != ah) op(OP_ADDR, 1'b1, a[15:8]);
            ah = a[15:8];
            op(OP_ADDR, 1'b0, a[7:0]);
            op(OP_READ, 1'b0, 8'h00);
            `CHK(q[15:8], d[7:0])
            op(OP_READ, 1'b1, 8'h00);
            `CHK(q[15:8], d[15:8])
        end
        $display("test flash done");
        op(OP_CMD, 1'b0, CMD_WR_EEPROM);
        ah = 8'($urandom_range(0, 7));
        op(OP_ADDR, 1'b1, ah);
        al = {5'($urandom), 3'h0};
        for (int k = 0; k < 3; k++) begin
            d = 16'($urandom);
            op(OP_ADDR, 1'b0, al);
            op(OP_DATA, 1'b0, d[7:0]);
            op(OP_LATCH, 1'b1, 8'h00);
            exp_e[int'({ah[2:0], al})] = d[7:0];
            al++;
        end
        op(OP_WRITE, 1'b0, 8'h00);
        foreach (exp_e[i]) `CHK(i_dev.rd_e(i), exp_e[i])
        $display("test eeprom done");
        fuse <= 1'b1;
        op(OP_CMD, 1'b0, CMD_ERASE);
        op(OP_WRITE, 1'b0, 8'h00);
        exp_f.delete();
        foreach (exp_e[i]) `CHK(i_dev.rd_e(i), exp_e[i])
        foreach (adrs[i]) `CHK(i_dev.rd_f(adrs[i]), ew(adrs[i]))
        $display("test preserve done");
        conclude();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        error_cnt++;
        conclude();
    end
endmodule

`default_nettype wire
